// ---- rtl/dsa_regs.vh ----
`ifndef DSA_REGS_VH
`define DSA_REGS_VH
// access size steps for post-increment
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002
// near region limits and direct field widths
`define DSA_NEAR_LAST 16'h1FFF
`define DSA_NEAR_BITS 13
`define DSA_FAR_BITS 16
`define DSA_WORD_BITS 16
// operation codes
`define DSA_OP_NONE 3'h0
`define DSA_OP_READ 3'h1
`define DSA_OP_WRITE 3'h2
`define DSA_OP_SIGN 3'h3
`define DSA_OP_ZERO 3'h4
// address modes
`define DSA_MODE_INDIRECT 2'h0
`define DSA_MODE_POSTINC 2'h1
`define DSA_MODE_NEAR 2'h2
`define DSA_MODE_FAR 2'h3
// reset values
`define DSA_ZERO_WORD 16'h0000
`define DSA_ZERO_BYTE 8'h00
`endif

// ---- rtl/dsa_access.v ----
`timescale 1ns/1ps
// Functional notes
// - post-increment advances pointer by one for bytes, two for words
// - byte read fetches whole word, address bit zero picks the byte
// - selected byte is returned on the low eight data bits
// - memory is two byte lanes, shared word decode, separate write strobes
// - byte write changes only the addressed lane
// - odd word access raises address error trap after the instruction
// - misaligned read lets the instruction complete normally
// - misaligned write stores nothing, but post-increment and eff_addr still update
// - byte load into working register changes only its low byte
// - sign widen turns signed byte into signed word
// - unsigned widen clears the working register high byte
// - near region 0000h-1FFFh reached by 13-bit direct field
// - space above near region through indirect addressing or far direct for transfer operations
// - transfer operations use a 16-bit direct address field
// - some operations are word-only; most accept byte or word
module dsa_access #(
    parameter ADDR_WIDTH = 16,
    parameter MEM_WORDS = 8192,
    parameter WREG_COUNT = 16
) (
    input wire ref_clk,
    input wire reset,
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [1:0] req_mode,
    input wire req_byte,
    input wire req_transfer_op,
    input wire req_word_only,
    input wire [3:0] req_wreg,
    input wire [3:0] req_ptr_reg,
    input wire [15:0] req_direct,
    input wire [15:0] req_wdata,
    input wire trap_taken,
    output wire [15:0] rd_data,
    output wire rd_valid,
    output wire addr_err_pending,
    output wire mode_err,
    output wire [15:0] eff_addr,
    output wire [15:0] wreg_view,
    input wire [3:0] wreg_view_sel
);

    `include "dsa_regs.vh"

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    // smallest index width that covers a depth
    function integer clog2_f;
        input integer depth;
        integer rem;
        begin
            rem = depth - 1;
            clog2_f = 0;
            while (rem > 0)
            begin
                rem = rem >> 1;
                clog2_f = clog2_f + 1;
            end
        end
    endfunction

    localparam WIDX = clog2_f(MEM_WORDS);
    localparam ADDR_MSB = ADDR_WIDTH - 1;
    localparam WORD_BITS = `DSA_WORD_BITS;
    localparam WREG_BITS = WREG_COUNT * WORD_BITS;

    // ------------------------------------------------------------
    // decoding functions
    // ------------------------------------------------------------
    // one working register out of the flat register bus
    function [15:0] wreg_pick;
        input [WREG_BITS-1:0] bus;
        input [3:0] idx;
        begin
            wreg_pick = bus[idx*WORD_BITS +: WORD_BITS];
        end
    endfunction

    // byte lane chosen by address bit zero
    function [7:0] byte_pick;
        input [15:0] word;
        input lsb;
        begin
            if (lsb)
                byte_pick = word[15:8];
            else
                byte_pick = word[7:0];
        end
    endfunction

    // words hit both lanes, bytes only their own
    function lane_we;
        input byte_op;
        input lsb;
        input hi_lane;
        begin
            lane_we = !byte_op || (lsb == hi_lane);
        end
    endfunction

    // ------------------------------------------------------------
    // storage: two byte lanes and the working register bus
    // ------------------------------------------------------------
    reg [7:0] lane_lo [0:MEM_WORDS-1];
    reg [7:0] lane_hi [0:MEM_WORDS-1];
    wire [WREG_BITS-1:0] wreg_bus;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    wire [15:0] ptr_cur = wreg_pick(wreg_bus, req_ptr_reg);
    wire [15:0] wr_cur = wreg_pick(wreg_bus, req_wreg);
    wire is_read = (req_op == `DSA_OP_READ);
    wire is_write = (req_op == `DSA_OP_WRITE);
    wire is_sign = (req_op == `DSA_OP_SIGN);
    wire is_zero = (req_op == `DSA_OP_ZERO);
    wire is_mem = is_read || is_write;
    wire is_postinc = (req_mode == `DSA_MODE_POSTINC);

    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    reg [ADDR_MSB:0] addr_calc;
    reg mode_ok;
    always @*
    begin
        addr_calc = {ADDR_WIDTH{1'b0}};
        mode_ok = 1'b1;
        case (req_mode)
            `DSA_MODE_INDIRECT, `DSA_MODE_POSTINC:
            begin
                addr_calc = ptr_cur;
            end
            `DSA_MODE_NEAR:
            begin
                addr_calc = {{(ADDR_WIDTH-`DSA_NEAR_BITS){1'b0}}, req_direct[`DSA_NEAR_BITS-1:0]};
            end
            `DSA_MODE_FAR:
            begin
                addr_calc = req_direct[`DSA_FAR_BITS-1:0];
                mode_ok = req_transfer_op;
            end
            default:
            begin
                addr_calc = {ADDR_WIDTH{1'b0}};
            end
        endcase
        if (req_word_only && req_byte)
        begin
            mode_ok = 1'b0;
        end
    end

    wire addr_lsb = addr_calc[0];
    wire [WIDX-1:0] word_idx = addr_calc[WIDX:1];
    wire misaligned = is_mem && !req_byte && addr_lsb;
    wire go = req_valid && mode_ok;
    wire rd_go = go && is_read;
    wire wr_go = go && is_write && !misaligned;
    wire ptr_inc = go && is_mem && is_postinc;
    wire [15:0] step = req_byte ? `DSA_STEP_BYTE : `DSA_STEP_WORD;
    wire [15:0] word_rd = {lane_hi[word_idx], lane_lo[word_idx]};
    wire [7:0] sel_byte = byte_pick(word_rd, addr_lsb);

    // ------------------------------------------------------------
    // memory lanes with separate write strobes
    // ------------------------------------------------------------
    wire we_lo = wr_go && lane_we(req_byte, addr_lsb, 1'b0);
    wire we_hi = wr_go && lane_we(req_byte, addr_lsb, 1'b1);
    wire [7:0] wdat_lo = req_wdata[7:0];
    wire [7:0] wdat_hi = req_byte ? req_wdata[7:0] : req_wdata[15:8];

    always @(posedge ref_clk)
    begin
        if (we_lo)
        begin
            lane_lo[word_idx] <= wdat_lo;
        end
        if (we_hi)
        begin
            lane_hi[word_idx] <= wdat_hi;
        end
    end

    // ------------------------------------------------------------
    // working registers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WREG_COUNT; gi = gi + 1)
        begin : g_wreg
            localparam [3:0] IDX = gi;
            reg [15:0] wreg_reg;
            reg [15:0] wreg_next;
            wire is_dest = (req_wreg == IDX);
            wire is_ptr = (req_ptr_reg == IDX);

            always @*
            begin
                wreg_next = wreg_reg;
                if (go && is_dest && is_sign)
                begin
                    wreg_next = {{8{wr_cur[7]}}, wr_cur[7:0]};
                end
                else if (go && is_dest && is_zero)
                begin
                    wreg_next = {`DSA_ZERO_BYTE, wr_cur[7:0]};
                end
                else if (rd_go && is_dest && req_byte)
                begin
                    wreg_next = {wreg_reg[15:8], sel_byte};
                end
                else if (rd_go && is_dest)
                begin
                    wreg_next = word_rd;
                end
                else if (ptr_inc && is_ptr)
                begin
                    wreg_next = wreg_reg + step;
                end
            end

            always @(posedge ref_clk)
            begin
                if (reset)
                begin
                    wreg_reg <= `DSA_ZERO_WORD;
                end
                else
                begin
                    wreg_reg <= wreg_next;
                end
            end

            assign wreg_bus[gi*WORD_BITS +: WORD_BITS] = wreg_reg;
        end
    endgenerate

    assign wreg_view = wreg_pick(wreg_bus, wreg_view_sel);

    // ------------------------------------------------------------
    // result, address and error reporting
    // ------------------------------------------------------------
    reg [15:0] rd_data_reg;
    reg [15:0] rd_data_next;
    reg rd_valid_reg;
    reg rd_valid_next;
    reg err_pend_reg;
    reg err_pend_next;
    reg mode_err_reg;
    reg mode_err_next;
    reg [15:0] eff_addr_reg;
    reg [15:0] eff_addr_next;

    always @*
    begin
        rd_data_next = rd_data_reg;
        rd_valid_next = rd_go;
        mode_err_next = req_valid && !mode_ok;
        eff_addr_next = eff_addr_reg;
        err_pend_next = err_pend_reg;
        if (rd_go)
        begin
            if (req_byte)
            begin
                rd_data_next = {`DSA_ZERO_BYTE, sel_byte};
            end
            else
            begin
                rd_data_next = word_rd;
            end
        end
        if (go && is_mem)
        begin
            eff_addr_next = addr_calc;
        end
        // a new fault wins over a trap taken in the same cycle
        if (go && misaligned)
        begin
            err_pend_next = 1'b1;
        end
        else if (trap_taken)
        begin
            err_pend_next = 1'b0;
        end
    end

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            rd_data_reg <= `DSA_ZERO_WORD;
            rd_valid_reg <= 1'b0;
            err_pend_reg <= 1'b0;
            mode_err_reg <= 1'b0;
            eff_addr_reg <= `DSA_ZERO_WORD;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            err_pend_reg <= err_pend_next;
            mode_err_reg <= mode_err_next;
            eff_addr_reg <= eff_addr_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign addr_err_pending = err_pend_reg;
    assign mode_err = mode_err_reg;
    assign eff_addr = eff_addr_reg;

endmodule // dsa_access

// ---- bench/dsa_props.sv ----
`timescale 1ns/1ps
module dsa_props (
    input wire ref_clk,
    input wire reset,
    input wire req_valid,
    input wire [2:0] req_op,
    input wire [1:0] req_mode,
    input wire req_byte,
    input wire req_transfer_op,
    input wire req_word_only,
    input wire [15:0] req_direct,
    input wire trap_taken,
    input wire [15:0] rd_data,
    input wire rd_valid,
    input wire addr_err_pending,
    input wire mode_err,
    input wire [15:0] eff_addr
);
wire mem = req_valid && (req_op == 3'h1 || req_op == 3'h2);
wire ok = mem && !(req_mode == 2'h3 && !req_transfer_op) && !(req_word_only && req_byte);
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
property p_rv; ok && req_op[0] |=> rd_valid; endproperty
a_rv: assert property (p_rv) else $error("no read answer");
property p_lo; ok && req_op[0] && req_byte |=> rd_data[15:8] == 8'h00; endproperty
a_lo: assert property (p_lo) else $error("byte not low");
property p_err; ok && !req_byte && req_mode[1] && req_direct[0] |=> addr_err_pending; endproperty
a_err: assert property (p_err) else $error("no addr error");
property p_hold; addr_err_pending && !trap_taken |=> addr_err_pending; endproperty
a_hold: assert property (p_hold) else $error("error dropped");
property p_clr; $fell(addr_err_pending) |-> $past(trap_taken); endproperty
a_clr: assert property (p_clr) else $error("error cleared early");
property p_far; mem && req_mode == 2'h3 && !req_transfer_op |=> mode_err; endproperty
a_far: assert property (p_far) else $error("far mode taken");
property p_wo; mem && req_word_only && req_byte |=> mode_err; endproperty
a_wo: assert property (p_wo) else $error("byte on word op");
property p_near; ok && req_mode == 2'h2 |=> eff_addr == {3'h0, $past(req_direct[12:0])}; endproperty
a_near: assert property (p_near) else $error("near address");
endmodule // dsa_props
bind dsa_access dsa_props i_dsa_props (
    .ref_clk(ref_clk),
    .reset(reset),
    .req_valid(req_valid),
    .req_op(req_op),
    .req_mode(req_mode),
    .req_byte(req_byte),
    .req_transfer_op(req_transfer_op),
    .req_word_only(req_word_only),
    .req_direct(req_direct),
    .trap_taken(trap_taken),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .addr_err_pending(addr_err_pending),
    .mode_err(mode_err),
    .eff_addr(eff_addr)
);

// ---- bench/dsa_trap_model.sv ----
`timescale 1ns/1ps
module dsa_trap_model (
    input wire ref_clk,
    input wire reset,
    input wire addr_err_pending,
    output reg trap_taken
);
reg [1:0] wait_reg;
always @(posedge ref_clk)
begin
    // count restarts on reset and while no fault is pending; a fault raised while one is pending does not restart it
    wait_reg <= (reset || !addr_err_pending) ? 2'h0 : wait_reg + 2'h1;
    trap_taken <= !reset && wait_reg == 2'h3;
end
endmodule // dsa_trap_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
reg ref_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_byte = 1'b0, req_transfer_op = 1'b0, req_word_only = 1'b0;
reg [2:0] req_op = 3'h0;
reg [1:0] req_mode = 2'h0;
reg [3:0] req_wreg = 4'h0, req_ptr_reg = 4'h2, wreg_view_sel = 4'h0;
reg [15:0] req_direct = 16'h0000, req_wdata = 16'h0000;
wire trap_taken, rd_valid, addr_err_pending, mode_err;
wire [15:0] rd_data, eff_addr, wreg_view;
integer fails = 0, cmp_count = 0, cyc = 0;
dsa_access i_dsa_access (
    .ref_clk(ref_clk),
    .reset(reset),
    .req_valid(req_valid),
    .req_op(req_op),
    .req_mode(req_mode),
    .req_byte(req_byte),
    .req_transfer_op(req_transfer_op),
    .req_word_only(req_word_only),
    .req_wreg(req_wreg),
    .req_ptr_reg(req_ptr_reg),
    .req_direct(req_direct),
    .req_wdata(req_wdata),
    .trap_taken(trap_taken),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .addr_err_pending(addr_err_pending),
    .mode_err(mode_err),
    .eff_addr(eff_addr),
    .wreg_view(wreg_view),
    .wreg_view_sel(wreg_view_sel)
);
dsa_trap_model i_dsa_trap_model (
    .ref_clk(ref_clk),
    .reset(reset),
    .addr_err_pending(addr_err_pending),
    .trap_taken(trap_taken)
);
always #50 ref_clk = ~ref_clk;
always @(posedge ref_clk)
begin
    cyc = cyc + 1;
    if (cyc == 400)
    begin
        fails = fails + 1;
        final_report;
    end
end
task final_report;
    if (fails == 0 && cmp_count > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task chk(input string n, input [15:0] e, input [15:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e)
    begin
        fails = fails + 1;
        $display("mismatch %s exp %h got %h", n, e, g);
    end
endtask
task chf(input string n, input e, input g);
    chk(n, {15'h0000, e}, {15'h0000, g});
endtask
// code is {transfer, word_only, byte, op}
task op(input [5:0] c, input [1:0] m, input [3:0] w, input [15:0] a, input [15:0] d);
    @(posedge ref_clk);
    {req_transfer_op, req_word_only, req_byte, req_op, req_mode, req_wreg} <= {c, m, w};
    {req_valid, wreg_view_sel, req_direct, req_wdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
endtask
task s_lanes;
    op(6'h02, 2'h2, 4'h1, 16'h0100, 16'hA5C3);
    op(6'h09, 2'h2, 4'h1, 16'h0101, 16'h0000);
    chk("byte", 16'h00A5, rd_data);
    chf("rvld", 1'b1, rd_valid);
    op(6'h0A, 2'h2, 4'h1, 16'h0100, 16'h005A);
    op(6'h01, 2'h2, 4'h2, 16'h0100, 16'h0000);
    chk("word", 16'hA55A, rd_data);
    op(6'h09, 2'h2, 4'h2, 16'h0101, 16'h0000);
    chk("load", 16'hA5A5, wreg_view);
    op(6'h03, 2'h0, 4'h2, 16'h0000, 16'h0000);
    chk("sign", 16'hFFA5, wreg_view);
    op(6'h04, 2'h0, 4'h2, 16'h0000, 16'h0000);
    chk("zero", 16'h00A5, wreg_view);
endtask
task s_post;
    op(6'h01, 2'h1, 4'h3, 16'h0000, 16'h0000);
    chf("odd", 1'b1, addr_err_pending);
    chf("rdone", 1'b1, rd_valid);
    op(6'h09, 2'h1, 4'h3, 16'h0000, 16'h0000);
    chk("ptr2", 16'h00A7, eff_addr);
    op(6'h09, 2'h0, 4'h3, 16'h0000, 16'h0000);
    chk("ptr1", 16'h00A8, eff_addr);
endtask
task s_wflt;
    op(6'h02, 2'h2, 4'h1, 16'h0101, 16'h1234);
    chf("werr", 1'b1, addr_err_pending);
    op(6'h01, 2'h2, 4'h1, 16'h0100, 16'h0000);
    chk("kept", 16'hA55A, rd_data);
endtask
task s_mode;
    op(6'h01, 2'h3, 4'h1, 16'h2100, 16'h0000);
    chf("far", 1'b1, mode_err);
    op(6'h19, 2'h2, 4'h1, 16'h0100, 16'h0000);
    chf("wonly", 1'b1, mode_err);
    repeat (4) @(posedge ref_clk);
    #1;
    chf("trap", 1'b0, addr_err_pending);
endtask
// far transfer above the near region, then indirect through a pointer there
task s_far;
    op(6'h22, 2'h3, 4'h0, 16'h2100, 16'h2100);
    op(6'h21, 2'h3, 4'h2, 16'h2100, 16'h0000);
    chk("fard", 16'h2100, rd_data);
    op(6'h01, 2'h0, 4'h4, 16'h0000, 16'h0000);
    chk("ind", 16'h2100, eff_addr);
    chk("indd", 16'h2100, rd_data);
endtask
initial
begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    s_lanes;
    s_post;
    s_wflt;
    s_mode;
    s_far;
    final_report;
end
endmodule // tb_top
